// >>> rtl/sld_top.sv
`include "sld_params.svh"
module sld_top (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire sld_pkg::sld_req_t i_req,
	output logic [31:0] o_rdata,
	output logic o_busy,
	output logic o_done,
	output sld_pkg::sld_op_t o_op
);
	import sld_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic prot_mode;
	logic op32;
	sld_state_t state;
	sld_state_t next_state;
	sld_dec_t cls;
	sld_dec_t dec_q;
	sld_exec_t ex_now;
	sld_exec_t p_q;
	sld_exec_t x_q;
	logic [2:0] tail_q;
	logic [2:0] next_tail;
	logic [7:0] flags_lo;
	logic df;
	logic ie;
	logic ts;
	logic [7:0] acc_high;
	logic [15:0] stack_img;
	logic [15:0] retired;
	logic [1:0] sticky;
	logic launch;
	logic ill;
	logic latch_dec;
	logic p_load;
	logic t_busy;
	logic t_fin;
	logic [31:0] status;
	logic [31:0] rd_mux;
	sld_op_t grp_op;

	// ----------------------------------------------------------------
	// register port decode
	// ----------------------------------------------------------------
	wire sel_ctrl = (i_req.addr == `SLD_REG_CTRL);
	wire sel_byte = (i_req.addr == `SLD_REG_BYTE);
	wire sel_status = (i_req.addr == `SLD_REG_STATUS);
	wire sel_flags = (i_req.addr == `SLD_REG_FLAGS);
	wire sel_acch = (i_req.addr == `SLD_REG_ACCH);
	wire sel_stack = (i_req.addr == `SLD_REG_STACK);
	wire sel_retired = (i_req.addr == `SLD_REG_RETIRED);
	wire byte_wr = i_req.wr && sel_byte;
	wire refuse = byte_wr && (state == st_exec);
	wire [7:0] in_byte = i_req.wdata[7:0];
	wire is_mem_byte = (in_byte[7:6] != `SLD_MOD_REG);
	wire [2:0] reg_fld = in_byte[5:3];
	wire [15:0] flags_word = {`SLD_IMG_PAD, ts, ie, df, flags_lo};

	// ----------------------------------------------------------------
	// operand length helpers
	// ----------------------------------------------------------------
	function automatic logic [2:0] full_len(input logic w, input logic wide);
		return w ? (wide ? `SLD_LEN_DWORD : `SLD_LEN_WORD) : `SLD_LEN_BYTE;
	endfunction : full_len

	function automatic logic [2:0] imm_len(input sld_dec_t d, input logic wide);
		case (d.imm)
			imm_byte: imm_len = `SLD_LEN_BYTE;
			imm_full: imm_len = full_len(d.w, wide);
			imm_sext: imm_len = d.d ? `SLD_LEN_BYTE : full_len(d.w, wide);
			default: imm_len = '0;
		endcase
	endfunction : imm_len

	// displacement bytes, 16-bit addressing
	function automatic logic [2:0] disp_len(input logic [7:0] m);
		case (m[7:6])
			`SLD_MOD_NODISP: disp_len = (m[2:0] == `SLD_RM_DIRECT) ? `SLD_LEN_WORD : '0;
			`SLD_MOD_DISP8: disp_len = `SLD_LEN_BYTE;
			`SLD_MOD_DISP16: disp_len = `SLD_LEN_WORD;
			default: disp_len = '0;
		endcase
	endfunction : disp_len

	// lower count for register operand, higher for memory
	function automatic logic [7:0] pick_clk(input sld_dec_t d, input logic mem, input logic prot);
		if (!mem) begin
			return d.clk_reg;
		end
		return prot ? d.clk_pmem : d.clk_mem;
	endfunction : pick_clk

	// ----------------------------------------------------------------
	// opcode classifier
	// ----------------------------------------------------------------
	always_comb begin
		cls = '0;
		cls.op = op_none;
		cls.d = in_byte[1];
		cls.w = in_byte[0];
		if (state == st_esc) begin
			case (in_byte)
				`SLD_OP2_LOAD_F: begin
					cls.op = op_load_far_ptr_fseg;
					cls.clk_pmem = `SLD_CLK_FAR_PROT_F;
				end
				`SLD_OP2_LOAD_G: begin
					cls.op = op_load_far_ptr_gseg;
					cls.clk_pmem = `SLD_CLK_FAR_PROT;
				end
				`SLD_OP2_LOAD_STACK: begin
					cls.op = op_load_far_ptr_stackseg;
					cls.clk_pmem = `SLD_CLK_FAR_PROT;
				end
				`SLD_OP2_TS_CLEAR: begin
					cls.op = op_task_switched_clear;
					cls.clk_reg = `SLD_CLK_TS_CLEAR;
				end
				default: begin
				end
			endcase
		end else begin
			casez (in_byte)
				`SLD_OP_LOAD_D: begin
					cls.op = op_load_far_ptr_dseg;
					cls.clk_pmem = `SLD_CLK_FAR_PROT;
				end
				`SLD_OP_LOAD_E: begin
					cls.op = op_load_far_ptr_eseg;
					cls.clk_pmem = `SLD_CLK_FAR_PROT;
				end
				`SLD_OP_CARRY_CLEAR: begin
					cls.op = op_carry_clear;
					cls.clk_reg = `SLD_CLK_FLAG;
				end
				`SLD_OP_DIR_CLEAR: begin
					cls.op = op_direction_clear;
					cls.clk_reg = `SLD_CLK_FLAG;
				end
				`SLD_OP_CARRY_SET: begin
					cls.op = op_carry_set;
					cls.clk_reg = `SLD_CLK_FLAG;
				end
				`SLD_OP_DIR_SET: begin
					cls.op = op_direction_set;
					cls.clk_reg = `SLD_CLK_FLAG;
				end
				`SLD_OP_CARRY_INVERT: begin
					cls.op = op_carry_invert;
					cls.clk_reg = `SLD_CLK_FLAG;
				end
				`SLD_OP_IE_SET: begin
					cls.op = op_int_enable_set;
					cls.clk_reg = `SLD_CLK_IE;
				end
				`SLD_OP_IE_CLEAR: begin
					cls.op = op_int_enable_clear;
					cls.clk_reg = `SLD_CLK_IE;
				end
				`SLD_OP_FLAGS_TO_ACCH: begin
					cls.op = op_flags_acc_high_transfer;
					cls.clk_reg = `SLD_CLK_FLAG;
				end
				`SLD_OP_ACCH_TO_FLAGS: begin
					cls.op = op_acc_high_to_flags;
					cls.clk_reg = `SLD_CLK_ACCH_TO_FLAGS;
				end
				`SLD_OP_FLAGS_POP: begin
					cls.op = op_flags_pop;
					cls.clk_reg = `SLD_CLK_FLAGS_POP;
				end
				`SLD_OP_FLAGS_PUSH: begin
					cls.op = op_flags_push;
					cls.clk_reg = `SLD_CLK_FLAGS_PUSH;
				end
				`SLD_OP_ADD_RM: begin
					cls.op = op_add;
					cls.modrm = 1'b1;
					cls.clk_reg = `SLD_CLK_ALU_REG;
					cls.clk_mem = in_byte[1] ? `SLD_CLK_MEM_SRC : `SLD_CLK_MEM_DST;
				end
				`SLD_OP_ADD_ACC: begin
					cls.op = op_add;
					cls.imm = imm_full;
					cls.clk_reg = `SLD_CLK_ALU_REG;
				end
				`SLD_OP_ADC_RM: begin
					cls.op = op_adc;
					cls.modrm = 1'b1;
					cls.clk_reg = `SLD_CLK_ALU_REG;
					cls.clk_mem = in_byte[1] ? `SLD_CLK_MEM_SRC : `SLD_CLK_MEM_DST;
				end
				`SLD_OP_ADC_ACC: begin
					cls.op = op_adc;
					cls.imm = imm_full;
					cls.clk_reg = `SLD_CLK_ALU_REG;
				end
				`SLD_OP_GRP_IMM: begin
					cls.op = op_add;
					cls.modrm = 1'b1;
					cls.grp = grp_arith;
					cls.imm = imm_sext;
					cls.clk_reg = `SLD_CLK_ALU_REG;
					cls.clk_mem = `SLD_CLK_MEM_DST;
				end
				`SLD_OP_GRP_INC: begin
					cls.op = op_inc;
					cls.modrm = 1'b1;
					cls.grp = grp_inc;
					cls.clk_reg = `SLD_CLK_ALU_REG;
					cls.clk_mem = `SLD_CLK_INC_MEM;
				end
				`SLD_OP_INC_SHORT: begin
					cls.op = op_inc;
					cls.clk_reg = `SLD_CLK_ALU_REG;
				end
				`SLD_OP_SUB_RM: begin
					cls.op = op_sub;
					cls.modrm = 1'b1;
					cls.reg_only = 1'b1;
					cls.clk_reg = `SLD_CLK_ALU_REG;
				end
				default: begin
				end
			endcase
		end
		// far loads always take a memory operand
		if (cls.clk_pmem == '0) begin
			cls.clk_pmem = cls.clk_mem;
		end else begin
			cls.modrm = 1'b1;
			cls.mem_only = 1'b1;
			cls.clk_reg = `SLD_CLK_FAR_REAL;
			cls.clk_mem = `SLD_CLK_FAR_REAL;
		end
	end

	// ----------------------------------------------------------------
	// ModR/M resolution
	// ----------------------------------------------------------------
	assign grp_op = (dec_q.grp == grp_arith && reg_fld == `SLD_GRP_ADC) ? op_adc : dec_q.op;
	wire grp_bad = (dec_q.grp == grp_arith && reg_fld != `SLD_GRP_ADD &&
		reg_fld != `SLD_GRP_ADC) || (dec_q.grp == grp_inc && reg_fld != `SLD_GRP_INC);
	wire form_bad = (dec_q.reg_only && is_mem_byte) || (dec_q.mem_only && !is_mem_byte);
	wire [2:0] tail_len = disp_len(in_byte) + imm_len(dec_q, op32);
	wire [2:0] first_len = imm_len(cls, op32);

	// instruction as known in the current byte
	always_comb begin
		case (state)
			st_modrm: ex_now = '{grp_op, is_mem_byte, dec_q.d, dec_q.w,
				pick_clk(dec_q, is_mem_byte, prot_mode)};
			st_tail: ex_now = p_q;
			default: ex_now = '{cls.op, 1'b0, cls.d, cls.w, cls.clk_reg};
		endcase
	end

	// ----------------------------------------------------------------
	// byte sequencer
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_tail = tail_q;
		launch = 1'b0;
		ill = 1'b0;
		latch_dec = 1'b0;
		p_load = 1'b0;
		case (state)
			st_idle, st_esc: begin
				if (byte_wr) begin
					if (state == st_idle && in_byte == `SLD_OP_ESC) begin
						next_state = st_esc;
					end else if (cls.op == op_none) begin
						ill = 1'b1;
						next_state = st_idle;
					end else if (cls.modrm) begin
						latch_dec = 1'b1;
						next_state = st_modrm;
					end else if (first_len != '0) begin
						p_load = 1'b1;
						next_tail = first_len;
						next_state = st_tail;
					end else begin
						launch = 1'b1;
					end
				end
			end
			st_modrm: begin
				if (byte_wr) begin
					if (grp_bad || form_bad) begin
						ill = 1'b1;
						next_state = st_idle;
					end else if (tail_len != '0) begin
						p_load = 1'b1;
						next_tail = tail_len;
						next_state = st_tail;
					end else begin
						launch = 1'b1;
					end
				end
			end
			st_tail: begin
				if (byte_wr) begin
					next_tail = tail_q - 3'h1;
					launch = (tail_q == 3'h1);
				end
			end
			st_exec: begin
				if (t_fin) begin
					next_state = st_idle;
				end
			end
			default: begin
				next_state = st_idle;
			end
		endcase
		if (launch) begin
			next_state = st_exec;
		end
	end

	// sequencer registers
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state <= st_idle;
			tail_q <= '0;
			dec_q <= '0;
			p_q <= '0;
			x_q <= '0;
		end else begin
			state <= next_state;
			tail_q <= next_tail;
			if (latch_dec) dec_q <= cls;
			if (p_load) p_q <= ex_now;
			if (launch) x_q <= ex_now;
		end
	end

	sld_timer #(
		.W(`SLD_CLK_W)
	) u_timer (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_load(launch),
		.i_count(ex_now.clk),
		.o_busy(t_busy),
		.o_fin(t_fin)
	);

	// illegal and refused flags
	sld_sticky #(
		.W(2)
	) u_sticky (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_set({refuse, ill}),
		.i_clr({2{i_req.wr && sel_status}} & i_req.wdata[`SLD_ST_REFUSED:`SLD_ST_ILLEGAL]),
		.o_q(sticky)
	);

	// ----------------------------------------------------------------
	// architectural flags, applied on the last execution clock
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			flags_lo <= `SLD_FLAGS_RST;
			df <= 1'b0;
			ie <= 1'b0;
			ts <= 1'b0;
			acc_high <= '0;
			stack_img <= '0;
		end else if (t_fin) begin
			case (x_q.op)
				op_carry_clear: flags_lo[`SLD_FL_CARRY] <= 1'b0;
				op_carry_set: flags_lo[`SLD_FL_CARRY] <= 1'b1;
				op_carry_invert: flags_lo[`SLD_FL_CARRY] <= ~flags_lo[`SLD_FL_CARRY];
				op_direction_clear: df <= 1'b0;
				op_direction_set: df <= 1'b1;
				op_int_enable_clear: ie <= 1'b0;
				op_int_enable_set: ie <= 1'b1;
				op_task_switched_clear: ts <= 1'b0;
				op_flags_acc_high_transfer: acc_high <= flags_lo;
				op_acc_high_to_flags: flags_lo <= (acc_high & `SLD_FLAGS_KEEP) | `SLD_FLAGS_ONE;
				op_flags_push: stack_img <= flags_word;
				op_flags_pop: begin
					flags_lo <= (stack_img[7:0] & `SLD_FLAGS_KEEP) | `SLD_FLAGS_ONE;
					df <= stack_img[`SLD_FL_DIR];
					ie <= stack_img[`SLD_FL_IE];
					ts <= stack_img[`SLD_FL_TS];
				end
				default: begin
				end
			endcase
		end else begin
			if (i_req.wr && sel_flags) begin
				flags_lo <= (i_req.wdata[7:0] & `SLD_FLAGS_KEEP) | `SLD_FLAGS_ONE;
				df <= i_req.wdata[`SLD_FL_DIR];
				ie <= i_req.wdata[`SLD_FL_IE];
				ts <= i_req.wdata[`SLD_FL_TS];
			end
			if (i_req.wr && sel_acch) acc_high <= i_req.wdata[7:0];
			if (i_req.wr && sel_stack) stack_img <= i_req.wdata[15:0];
		end
	end

	// ----------------------------------------------------------------
	// control, outputs and read port
	// ----------------------------------------------------------------
	always_comb begin
		status = '0;
		status[`SLD_ST_BUSY] = o_busy;
		status[`SLD_ST_ILLEGAL] = sticky[0];
		status[`SLD_ST_REFUSED] = sticky[1];
		status[`SLD_ST_DECODING] = (state != st_idle) && (state != st_exec);
		status[`SLD_ST_OP_LSB +: 5] = x_q.op;
		status[`SLD_ST_CLK_LSB +: `SLD_CLK_W] = x_q.clk;
		status[`SLD_ST_D] = x_q.d;
		status[`SLD_ST_W] = x_q.w;
		status[`SLD_ST_MEM] = x_q.mem;
		status[`SLD_ST_PROT] = prot_mode;
	end

	assign rd_mux = sel_ctrl ? {30'h0, op32, prot_mode} :
		sel_status ? status :
		sel_flags ? {16'h0, flags_word} :
		sel_acch ? {24'h0, acc_high} :
		sel_stack ? {16'h0, stack_img} :
		sel_retired ? {16'h0, retired} : 32'h0;

	// mode bits, counters and port outputs
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			prot_mode <= 1'b0;
			op32 <= 1'b0;
			retired <= '0;
			o_rdata <= '0;
			o_busy <= 1'b0;
			o_done <= 1'b0;
			o_op <= op_none;
		end else begin
			if (i_req.wr && sel_ctrl) begin
				prot_mode <= i_req.wdata[`SLD_CTRL_PROT];
				op32 <= i_req.wdata[`SLD_CTRL_OP32];
			end
			if (t_fin) retired <= retired + 16'h1;
			o_rdata <= i_req.rd ? rd_mux : 32'h0;
			o_busy <= launch || (t_busy && !t_fin);
			o_done <= t_fin;
			if (launch) o_op <= ex_now.op;
		end
	end
endmodule : sld_top

// >>> rtl/sld_params.svh
`ifndef SLD_PARAMS_SVH
`define SLD_PARAMS_SVH
// ----------------------------------------------------------------
// register map and fields
// ----------------------------------------------------------------
`define SLD_REG_CTRL 8'h00
`define SLD_REG_BYTE 8'h04
`define SLD_REG_STATUS 8'h08
`define SLD_REG_FLAGS 8'h0C
`define SLD_REG_ACCH 8'h10
`define SLD_REG_STACK 8'h14
`define SLD_REG_RETIRED 8'h18
`define SLD_CTRL_PROT 0
`define SLD_CTRL_OP32 1
`define SLD_ST_BUSY 0
`define SLD_ST_ILLEGAL 1
`define SLD_ST_REFUSED 2
`define SLD_ST_DECODING 3
`define SLD_ST_OP_LSB 8
`define SLD_ST_CLK_LSB 16
`define SLD_ST_D 24
`define SLD_ST_W 25
`define SLD_ST_MEM 26
`define SLD_ST_PROT 27
`define SLD_FL_CARRY 0
`define SLD_FL_DIR 8
`define SLD_FL_IE 9
`define SLD_FL_TS 10
`define SLD_FLAGS_RST 8'h02
`define SLD_FLAGS_KEEP 8'hD5
`define SLD_FLAGS_ONE 8'h02
`define SLD_IMG_PAD 5'h00
// ----------------------------------------------------------------
// opcodes and ModR/M fields
// ----------------------------------------------------------------
`define SLD_OP_ESC 8'h0F
`define SLD_OP_LOAD_D 8'hC5
`define SLD_OP_LOAD_E 8'hC4
`define SLD_OP2_LOAD_F 8'hB4
`define SLD_OP2_LOAD_G 8'hB5
`define SLD_OP2_LOAD_STACK 8'hB2
`define SLD_OP2_TS_CLEAR 8'h06
`define SLD_OP_CARRY_CLEAR 8'hF8
`define SLD_OP_CARRY_SET 8'hF9
`define SLD_OP_CARRY_INVERT 8'hF5
`define SLD_OP_DIR_CLEAR 8'hFC
`define SLD_OP_DIR_SET 8'hFD
`define SLD_OP_IE_CLEAR 8'hFA
`define SLD_OP_IE_SET 8'hFB
`define SLD_OP_FLAGS_TO_ACCH 8'h9F
`define SLD_OP_ACCH_TO_FLAGS 8'h9E
`define SLD_OP_FLAGS_POP 8'h9D
`define SLD_OP_FLAGS_PUSH 8'h9C
`define SLD_OP_ADD_RM 8'b000000??
`define SLD_OP_ADD_ACC 8'b0000010?
`define SLD_OP_ADC_RM 8'b000100??
`define SLD_OP_ADC_ACC 8'b0001010?
`define SLD_OP_GRP_IMM 8'b100000??
`define SLD_OP_GRP_INC 8'b1111111?
`define SLD_OP_INC_SHORT 8'b01000???
`define SLD_OP_SUB_RM 8'b001010??
`define SLD_MOD_REG 2'b11
`define SLD_MOD_NODISP 2'b00
`define SLD_MOD_DISP8 2'b01
`define SLD_MOD_DISP16 2'b10
`define SLD_RM_DIRECT 3'b110
`define SLD_GRP_ADD 3'h0
`define SLD_GRP_ADC 3'h2
`define SLD_GRP_INC 3'h0
`define SLD_LEN_BYTE 3'h1
`define SLD_LEN_WORD 3'h2
`define SLD_LEN_DWORD 3'h4
// ----------------------------------------------------------------
// clock counts in processor clocks
// ----------------------------------------------------------------
`define SLD_CLK_W 8
`define SLD_CLK_FAR_REAL 8'h07
`define SLD_CLK_FAR_PROT 8'h1C
`define SLD_CLK_FAR_PROT_F 8'h1F
`define SLD_CLK_FLAG 8'h02
`define SLD_CLK_IE 8'h08
`define SLD_CLK_TS_CLEAR 8'h05
`define SLD_CLK_ACCH_TO_FLAGS 8'h03
`define SLD_CLK_FLAGS_POP 8'h05
`define SLD_CLK_FLAGS_PUSH 8'h04
`define SLD_CLK_ALU_REG 8'h02
`define SLD_CLK_MEM_DST 8'h07
`define SLD_CLK_MEM_SRC 8'h06
`define SLD_CLK_INC_MEM 8'h06
`endif

// >>> rtl/sld_pkg.sv
`include "sld_params.svh"
package sld_pkg;
	// decoded operation
	typedef enum logic [4:0] {
		op_none = 5'h00,
		op_load_far_ptr_dseg = 5'h01,
		op_load_far_ptr_eseg = 5'h02,
		op_load_far_ptr_fseg = 5'h03,
		op_load_far_ptr_gseg = 5'h04,
		op_load_far_ptr_stackseg = 5'h05,
		op_carry_clear = 5'h06,
		op_direction_clear = 5'h07,
		op_int_enable_clear = 5'h08,
		op_task_switched_clear = 5'h09,
		op_carry_invert = 5'h0A,
		op_flags_acc_high_transfer = 5'h0B,
		op_acc_high_to_flags = 5'h0C,
		op_flags_pop = 5'h0D,
		op_flags_push = 5'h0E,
		op_carry_set = 5'h0F,
		op_direction_set = 5'h10,
		op_int_enable_set = 5'h11,
		op_add = 5'h12,
		op_adc = 5'h13,
		op_inc = 5'h14,
		op_sub = 5'h15
	} sld_op_t;
	typedef enum logic [2:0] {
		st_idle = 3'b000,
		st_esc = 3'b001,
		st_modrm = 3'b010,
		st_tail = 3'b011,
		st_exec = 3'b100
	} sld_state_t;
	typedef enum logic [1:0] {
		imm_none = 2'b00,
		imm_byte = 2'b01,
		imm_full = 2'b10,
		imm_sext = 2'b11
	} sld_imm_t;
	typedef enum logic [1:0] {
		grp_none = 2'b00,
		grp_arith = 2'b01,
		grp_inc = 2'b10
	} sld_grp_t;
	// first-byte decode result
	typedef struct packed {
		sld_op_t op;
		logic modrm;
		sld_imm_t imm;
		sld_grp_t grp;
		logic reg_only;
		logic mem_only;
		logic d;
		logic w;
		logic [`SLD_CLK_W-1:0] clk_reg;
		logic [`SLD_CLK_W-1:0] clk_mem;
		logic [`SLD_CLK_W-1:0] clk_pmem;
	} sld_dec_t;
	// fully resolved instruction
	typedef struct packed {
		sld_op_t op;
		logic mem;
		logic d;
		logic w;
		logic [`SLD_CLK_W-1:0] clk;
	} sld_exec_t;
	// register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} sld_req_t;
endpackage : sld_pkg

// >>> rtl/sld_timer.sv
module sld_timer #(
	parameter int W = 8
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_load,
	input wire logic [W-1:0] i_count,
	output logic o_busy,
	output logic o_fin
);
	logic [W-1:0] cnt;

	// remaining execution clocks
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt <= '0;
		end else if (i_load) begin
			cnt <= i_count;
		end else if (o_busy) begin
			cnt <= cnt - W'(1);
		end
	end

	assign o_busy = (cnt != '0);
	assign o_fin = (cnt == W'(1)); // last busy clock
endmodule : sld_timer

// >>> rtl/sld_sticky.sv
module sld_sticky #(
	parameter int W = 1
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [W-1:0] i_set,
	input wire logic [W-1:0] i_clr,
	output logic [W-1:0] o_q
);
	// set wins over a clear in the same cycle
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_q <= '0;
		end else begin
			o_q <= (o_q & ~i_clr) | i_set;
		end
	end
endmodule : sld_sticky

// >>> bench/sld_top_sva.sv
module sld_top_sva (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire sld_pkg::sld_req_t i_req,
	input wire logic [31:0] o_rdata,
	input wire logic o_busy,
	input wire logic o_done,
	input wire sld_pkg::sld_op_t o_op
);
	import sld_pkg::*;
	logic prot;
	logic [5:0] cnt;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// track mode bit and count busy cycles
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			prot <= 1'b0;
			cnt <= 6'h00;
		end else begin
			if (i_req.wr && i_req.addr == 8'h00)
				prot <= i_req.wdata[0];
			cnt <= o_busy ? cnt + 6'h01 : 6'h00;
		end
	end
	// clock count seen at completion
	a_far_count: assert property (
		o_done && o_op inside {[op_load_far_ptr_dseg:op_load_far_ptr_stackseg]} |-> cnt ==
		(!prot ? 6'h07 : o_op == op_load_far_ptr_fseg ? 6'h1F : 6'h1C)) else $error("far count");
	a_flag_two: assert property (
		$rose(o_busy) && o_op inside {op_carry_clear, op_carry_set, op_carry_invert,
		op_direction_clear, op_direction_set} |-> o_busy[*2] ##1 o_done) else $error("flag count");
	a_ie_eight: assert property (
		$rose(o_busy) && o_op inside {op_int_enable_clear, op_int_enable_set}
		|-> o_busy[*8] ##1 o_done) else $error("ie count");
	a_ts_five: assert property (
		o_done && o_op == op_task_switched_clear |-> cnt == 6'h05) else $error("ts count");
	a_acch_count: assert property (
		o_done && o_op inside {op_flags_acc_high_transfer, op_acc_high_to_flags} |->
		cnt == (o_op == op_acc_high_to_flags ? 6'h03 : 6'h02)) else $error("acc count");
	a_stack_count: assert property (
		o_done && o_op inside {op_flags_pop, op_flags_push} |->
		cnt == (o_op == op_flags_pop ? 6'h05 : 6'h04)) else $error("stack count");
	a_add_count: assert property (
		o_done && o_op inside {op_add, op_adc} |-> cnt inside {6'h02, 6'h06, 6'h07})
		else $error("add count");
	a_inc_sub: assert property (
		o_done && o_op inside {op_inc, op_sub} |-> cnt == 6'h02 || (o_op == op_inc && cnt == 6'h06))
		else $error("inc sub count");
endmodule : sld_top_sva
bind sld_top sld_top_sva sld_top_sva_inst (.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req),
	.o_rdata(o_rdata), .o_busy(o_busy), .o_done(o_done), .o_op(o_op));

// >>> bench/test_sld_top.sv
module test_sld_top;
	timeunit 1ns;
	timeprecision 1ns;
	import sld_pkg::*;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	sld_req_t i_req = '0;
	logic [31:0] o_rdata;
	logic o_busy;
	logic o_done;
	sld_op_t o_op;
	int fails = 0;
	int samples_checked = 0;
	int run_len = 0;
	int last_len = 0;
	int m;
	logic [31:0] r = 32'h25B0F859;
	logic [31:0] d;
	logic [7:0] mr;
	logic [7:0] rr;
	logic [10:0] fm = 11'h002;
	logic [7:0] acch = 8'h00;
	logic [15:0] stk = 16'h0000;
	logic [7:0] fo [7] = '{8'hF8, 8'hF9, 8'hF5, 8'hFC, 8'hFD, 8'hFA, 8'hFB};
	sld_op_t fop [7] = '{op_carry_clear, op_carry_set, op_carry_invert, op_direction_clear,
		op_direction_set, op_int_enable_clear, op_int_enable_set};
	always #5 i_clk = ~i_clk;
	sld_top sld_top_inst (.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req), .o_rdata(o_rdata),
		.o_busy(o_busy), .o_done(o_done), .o_op(o_op));
	// length of the busy run that just ended
	always @(posedge i_clk) begin
		if (o_done === 1'b1)
			last_len <= run_len;
		run_len <= (o_busy === 1'b1) ? run_len + 1 : 0;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		i_req <= '{a, v, 1'b1, 1'b0};
		@(posedge i_clk);
		i_req <= '0;
		@(posedge i_clk);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		i_req <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge i_clk);
		i_req <= '0;
		#1 d = o_rdata;
		@(posedge i_clk);
	endtask : rd
	// feed one instruction, time it, update the model, compare state
	task automatic ins(input logic [63:0] b, input int nb, input sld_op_t op, input int n);
		int k;
		logic [7:0] ob;
		for (k = 0; k < nb; k++)
			wr(8'h04, {24'h0, b[8*k+:8]});
		for (k = 0; k < 60; k++) begin
			@(posedge i_clk);
			#1;
			if (o_done === 1'b1)
				break;
		end
		if (k == 60) begin
			fails++;
			results();
		end
		chk(o_op, op);
		@(posedge i_clk);
		rd(8'h08);
		chk(last_len, n);
		chk(d[23:16], n);
		chk(d[12:8], op);
		ob = (b[7:0] == 8'h0F) ? b[15:8] : b[7:0];
		chk(d[25:24], {ob[0], ob[1]});
		case (b[7:0])
			8'hF8: fm[0] = 1'b0;
			8'hF9: fm[0] = 1'b1;
			8'hF5: fm[0] = ~fm[0];
			8'hFC: fm[8] = 1'b0;
			8'hFD: fm[8] = 1'b1;
			8'hFA: fm[9] = 1'b0;
			8'hFB: fm[9] = 1'b1;
			8'h0F: if (b[15:8] == 8'h06) fm[10] = 1'b0;
			8'h9F: acch = fm[7:0];
			8'h9E: fm[7:0] = acch & 8'hD5 | 8'h02;
			8'h9C: stk = {5'h00, fm};
			8'h9D: fm = stk[10:0];
			default: ;
		endcase
		rd(8'h0C);
		chk(d, fm);
		rd(8'h10);
		chk(d, acch);
		rd(8'h14);
		chk(d, stk);
	endtask : ins
	// real mode pass, then protected mode pass
	initial begin
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		rd(8'h0C);
		chk(d, 32'h2);
		for (m = 0; m < 2; m++) begin
			wr(8'h00, m);
			foreach (fo[i]) ins(fo[i], 1, fop[i], fo[i] inside {8'hFA, 8'hFB} ? 8 : 2);
			fm[10] = 1'b1;
			wr(8'h0C, {21'h0, fm});
			ins(32'h060F, 2, op_task_switched_clear, 5);
			r = lfsr(r);
			acch = r[7:0];
			mr = {2'b00, r[5:3], 1'b0, r[1:0]};
			rr = {2'b11, r[5:0]};
			wr(8'h10, {24'h0, acch});
			ins(32'h9E, 1, op_acc_high_to_flags, 3);
			ins(32'h9F, 1, op_flags_acc_high_transfer, 2);
			ins(32'h9C, 1, op_flags_push, 4);
			ins(32'hF5, 1, op_carry_invert, 2);
			ins(32'h9D, 1, op_flags_pop, 5);
			ins({16'h0, mr, 8'hC5}, 2, op_load_far_ptr_dseg, m ? 28 : 7);
			ins({16'h0, mr, 8'hC4}, 2, op_load_far_ptr_eseg, m ? 28 : 7);
			ins({8'h0, mr, 16'hB40F}, 3, op_load_far_ptr_fseg, m ? 31 : 7);
			ins({8'h0, mr, 16'hB50F}, 3, op_load_far_ptr_gseg, m ? 28 : 7);
			ins({8'h0, mr, 16'hB20F}, 3, op_load_far_ptr_stackseg, m ? 28 : 7);
			ins({16'h0, rr, 7'h00, r[8]}, 2, op_add, 2);
			ins({16'h0, mr, 7'h00, r[8]}, 2, op_add, 7);
			ins({16'h0, mr, 7'h01, r[8]}, 2, op_add, 6);
			ins({8'h0, r[23:16], 5'h18, r[2:0], 6'h20, r[8], r[8]}, 3, op_add, 2);
			ins({8'h0, r[23:16], 6'h00, r[1:0], 6'h20, r[8], r[8]}, 3, op_add, 7);
			ins({16'h0, r[23:16], 8'h04}, 2, op_add, 2);
			ins({16'h0, rr, 7'h08, r[8]}, 2, op_adc, 2);
			ins({16'h0, mr, 7'h08, r[8]}, 2, op_adc, 7);
			ins({16'h0, mr, 7'h09, r[8]}, 2, op_adc, 6);
			ins({8'h0, r[23:16], 5'h1A, r[2:0], 6'h20, r[8], r[8]}, 3, op_adc, 2);
			ins({8'h0, r[23:16], 6'h04, r[1:0], 6'h20, r[8], r[8]}, 3, op_adc, 7);
			ins({16'h0, r[23:16], 8'h14}, 2, op_adc, 2);
			ins({16'h0, 5'h18, r[2:0], 7'h7F, r[8]}, 2, op_inc, 2);
			ins({16'h0, 6'h00, r[1:0], 7'h7F, r[8]}, 2, op_inc, 6);
			ins({24'h0, 5'h08, r[2:0]}, 1, op_inc, 2);
			ins({16'h0, rr, 6'h0A, r[9], r[8]}, 2, op_sub, 2);
		end
		// 32-bit immediates and displaced memory operands
		wr(8'h00, 32'h2);
		r = lfsr(r);
		ins({r[31:0], 8'h05}, 5, op_add, 2);
		ins({r[31:0], r[15:8], 5'h08, r[2:0], 8'h81}, 7, op_add, 7);
		ins({r[15:0], 2'b10, r[5:0], 8'h00}, 4, op_add, 7);
		ins({r[15:0], 2'b00, r[5:3], 3'b110, 8'h03}, 4, op_add, 6);
		// bad group field, byte refused while busy, sticky clear
		wr(8'h04, 32'h80);
		wr(8'h04, 32'hC8);
		wr(8'h04, 32'hFB);
		wr(8'h04, 32'hF8);
		repeat (10) @(posedge i_clk);
		fm[9] = 1'b1;
		rd(8'h08);
		chk(d[3:0], 4'h6);
		rd(8'h0C);
		chk(d, fm);
		wr(8'h08, 32'h6);
		rd(8'h08);
		chk(d[3:0], 4'h0);
		// mid-run reset returns the flags to their reset value
		i_rst <= 1'b1;
		@(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		rd(8'h0C);
		chk(d, 32'h2);
		results();
	end
endmodule : test_sld_top
